// ==== rtl/bcs_consts.svh ====
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

// clock and timing
`define BCS_CLK_NS          50
`define BCS_NS_PER_MS       1000000
`define BCS_SLEW_MV_PER_MS  3000
`define BCS_EXT_RAMP_NS     1560000
`define BCS_HICCUP_MS       1
// cycles per 1 mV step at the preset slew rate, rounded up
`define BCS_SLEW_STEP_CYC   ((`BCS_NS_PER_MS + `BCS_SLEW_MV_PER_MS * `BCS_CLK_NS - 1) / \
                             (`BCS_SLEW_MV_PER_MS * `BCS_CLK_NS))
// cycles per step so the divider-mode ramp lasts at least the minimum time
`define BCS_EXT_STEP_CYC    ((`BCS_EXT_RAMP_NS + `BCS_MV_EXT * `BCS_CLK_NS - 1) / \
                             (`BCS_MV_EXT * `BCS_CLK_NS))
`define BCS_HICCUP_CYC      (`BCS_HICCUP_MS * `BCS_NS_PER_MS / `BCS_CLK_NS)
`define BCS_STEP_W          6
`define BCS_HIC_W           15

// setpoint codes in millivolts
`define BCS_CODE_W          12
`define BCS_MV_3V3          12'hCE4
`define BCS_MV_2V5          12'h9C4
`define BCS_MV_2V8          12'hAF0
`define BCS_MV_1V2          12'h4B0
`define BCS_MV_3V0          12'hBB8
`define BCS_MV_1V8          12'h708
`define BCS_MV_2V7          12'hA8C
`define BCS_MV_EXT          12'h25B

// register map
`define BCS_ADDR_W          8
`define BCS_REG_CTRL        8'h00
`define BCS_REG_STATUS      8'h04
`define BCS_REG_SETPOINT    8'h08
`define BCS_REG_TARGET      8'h0C
`define BCS_CTRL_RST        1'b1
`define BCS_RESP_OKAY       2'h0
`define BCS_RESP_SLVERR     2'h2

// status fields
`define BCS_ST_STATE        2:0
`define BCS_ST_LOCK         3
`define BCS_ST_THERM        4
`define BCS_ST_OC           5
`define BCS_ST_EXT          6
`define BCS_ST_ATTGT        7
`define BCS_ST_HICNT        15:8
`define BCS_ST_ZERO         31:16

`endif

// ==== rtl/bcs_pkg.sv ====
package bcs_pkg;
    typedef enum logic [2:0] {
        BCS_OFF,
        BCS_RAMP,
        BCS_REG,
        BCS_HICCUP,
        BCS_THERMAL
    } bcs_state_e;
    typedef logic [11:0] bcs_code_t;
endpackage

// ==== rtl/bcs_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module bcs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;

    // three stages per bit; output moves only when stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                s1_q[i]  <= 1'b0;
                s2_q[i]  <= 1'b0;
                s3_q[i]  <= 1'b0;
                out_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= din[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign dout = out_q;
endmodule // bcs_sync

`default_nettype wire

// ==== rtl/bcs_sequencer.sv ====
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "bcs_consts.svh"

// Summary of operation
// - start every power-up or enable through a soft-start ramp from zero
// - preset levels ramp at constant slew, so duration scales with target
// - divider mode ramps in constant time, at least 1.56 ms
// - overcurrent turns high side off, low side on, pulling output low
// - hold output low for 1 ms, then restart with soft start
// - persistent overcurrent repeats hold and restart endlessly
// - no switching at power-up until supply lockout releases
// - supply drop locks out again, with hysteresis against chatter
// - enable low means shutdown, switching stopped
// - enable high means regulation, entered through soft start
// - over-temperature turns the output off to cool
// - after cooling 15 C below trip, restart through normal startup
// - decode select bits into the seven preset voltages
// - select code 111 picks divider feedback against 0.603 V
// - decoded value drives the reference code of the error amplifier
module bcs_sequencer #(
    parameter int HICCUP_CYCLES = `BCS_HICCUP_CYC
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`BCS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`BCS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   enable_pin,
    input  wire logic                   volt_sel_bit0,
    input  wire logic                   volt_sel_bit1,
    input  wire logic                   volt_sel_bit2,
    input  wire logic                   supply_above_rise,
    input  wire logic                   supply_above_fall,
    input  wire logic                   hs_overcurrent,
    input  wire logic                   temp_above_trip,
    input  wire logic                   temp_above_cool,
    output logic                        switch_en,
    output logic                        hs_off_ls_on,
    output logic [`BCS_CODE_W-1:0]      ref_code,
    output logic                        use_divider_feedback_pin
);
    logic [8:0]             pins_raw;
    logic [8:0]             pins_s;
    logic                   en_s;
    logic [2:0]             sel_s;
    logic                   sup_rise_s;
    logic                   sup_fall_s;
    logic                   oc_s;
    logic                   trip_s;
    logic                   cool_s;
    bcs_pkg::bcs_state_e    state_q;
    bcs_pkg::bcs_state_e    state_d;
    logic                   lockout_q;
    logic                   lockout_d;
    logic                   thermal_q;
    logic                   thermal_d;
    logic                   ctrl_en_q;
    logic                   ext_mode_q;
    logic                   ext_mode_d;
    logic                   mode_now;
    logic                   sel_ext;
    bcs_pkg::bcs_code_t     preset_code;
    bcs_pkg::bcs_code_t     target_q;
    bcs_pkg::bcs_code_t     target_d;
    bcs_pkg::bcs_code_t     ref_q;
    bcs_pkg::bcs_code_t     ref_d;
    logic [`BCS_STEP_W-1:0] step_cnt_q;
    logic [`BCS_STEP_W-1:0] step_len;
    logic                   step_tick;
    logic                   active_q;
    logic                   active_d;
    logic                   at_target;
    logic [`BCS_HIC_W-1:0]  hic_cnt_q;
    logic                   hic_done;
    logic [7:0]             hic_events_q;
    logic                   run_req;
    logic                   sw_en_q;
    logic                   lsh_q;

    assign pins_raw = {temp_above_cool, temp_above_trip, hs_overcurrent, supply_above_fall,
                       supply_above_rise, volt_sel_bit2, volt_sel_bit1, volt_sel_bit0,
                       enable_pin};

    bcs_sync #(
        .WIDTH (9)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (pins_raw),
        .dout    (pins_s)
    );

    assign en_s       = pins_s[0];
    assign sel_s      = pins_s[3:1];
    assign sup_rise_s = pins_s[4];
    assign sup_fall_s = pins_s[5];
    assign oc_s       = pins_s[6];
    assign trip_s     = pins_s[7];
    assign cool_s     = pins_s[8];

    // lockout with hysteresis, rise releases, fall sets
    assign lockout_d = lockout_q ? !sup_rise_s : !sup_fall_s;
    // thermal hold until below the cool threshold; trip wins
    assign thermal_d = trip_s | (thermal_q & cool_s);

    // run request gated by enable pin and software enable
    assign run_req = en_s & ctrl_en_q & !lockout_q & !thermal_q;

    assign preset_code = (sel_s == 3'h0) ? `BCS_MV_3V3 :
                         (sel_s == 3'h1) ? `BCS_MV_2V5 :
                         (sel_s == 3'h2) ? `BCS_MV_2V8 :
                         (sel_s == 3'h3) ? `BCS_MV_1V2 :
                         (sel_s == 3'h4) ? `BCS_MV_3V0 :
                         (sel_s == 3'h5) ? `BCS_MV_1V8 : `BCS_MV_2V7;

    // divider mode latched only while off
    assign sel_ext    = &sel_s;
    assign mode_now   = (state_q == bcs_pkg::BCS_OFF) ? sel_ext : ext_mode_q;
    assign ext_mode_d = mode_now;
    // target code for the reference converter
    assign target_d   = mode_now ? `BCS_MV_EXT : (sel_ext ? target_q : preset_code);

    assign step_len  = ext_mode_q ? `BCS_STEP_W'(`BCS_EXT_STEP_CYC)
                                  : `BCS_STEP_W'(`BCS_SLEW_STEP_CYC);
    assign step_tick = active_q && (step_cnt_q == step_len - `BCS_STEP_W'(1));
    assign at_target = (ref_q == target_q);
    assign hic_done  = (hic_cnt_q == `BCS_HIC_W'(HICCUP_CYCLES - 1));
    assign active_d  = (state_d == bcs_pkg::BCS_RAMP) || (state_d == bcs_pkg::BCS_REG);

    // setpoint follows target one step per tick, zero when inactive
    always_comb begin
        ref_d = ref_q;
        if (!active_d) begin
            ref_d = '0;
        end else if (step_tick && (ref_q < target_q)) begin
            ref_d = ref_q + 12'h001;
        end else if (step_tick && (ref_q > target_q)) begin
            ref_d = ref_q - 12'h001;
        end
    end

    // sequencing state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            bcs_pkg::BCS_OFF: begin
                if (run_req) state_d = bcs_pkg::BCS_RAMP;
            end
            bcs_pkg::BCS_RAMP: begin
                if (at_target) state_d = bcs_pkg::BCS_REG;
            end
            bcs_pkg::BCS_REG: begin
                state_d = bcs_pkg::BCS_REG;
            end
            bcs_pkg::BCS_HICCUP: begin
                if (hic_done) state_d = bcs_pkg::BCS_RAMP;
            end
            bcs_pkg::BCS_THERMAL: begin
                if (!thermal_q) state_d = bcs_pkg::BCS_OFF;
            end
        endcase
        // overcurrent while switching starts a hiccup
        if (oc_s && active_q) state_d = bcs_pkg::BCS_HICCUP;
        if (!run_req) state_d = thermal_q ? bcs_pkg::BCS_THERMAL : bcs_pkg::BCS_OFF;
    end

    // state, flags and setpoint registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= bcs_pkg::BCS_OFF;
            lockout_q  <= 1'b1;
            thermal_q  <= 1'b0;
            ext_mode_q <= 1'b0;
            target_q   <= '0;
            ref_q      <= '0;
            active_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            lockout_q  <= lockout_d;
            thermal_q  <= thermal_d;
            ext_mode_q <= ext_mode_d;
            target_q   <= target_d;
            ref_q      <= ref_d;
            active_q   <= active_d;
        end
    end

    // step and hiccup counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_cnt_q   <= '0;
            hic_cnt_q    <= '0;
            hic_events_q <= '0;
        end else begin
            step_cnt_q <= (!active_q || step_tick) ? '0 : step_cnt_q + `BCS_STEP_W'(1);
            hic_cnt_q  <= (state_q == bcs_pkg::BCS_HICCUP) ? hic_cnt_q + `BCS_HIC_W'(1) : '0;
            if (state_d == bcs_pkg::BCS_HICCUP && state_q != bcs_pkg::BCS_HICCUP
                && hic_events_q != 8'hFF) begin
                hic_events_q <= hic_events_q + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_en_q <= 1'b0;
            lsh_q   <= 1'b0;
        end else begin
            sw_en_q <= active_d;
            lsh_q   <= (state_d == bcs_pkg::BCS_HICCUP);
        end
    end

    assign switch_en                = sw_en_q;
    assign hs_off_ls_on             = lsh_q;
    assign ref_code                 = ref_q;
    assign use_divider_feedback_pin = ext_mode_q;

    // ---- register slave ----
    logic                   aw_held_q;
    logic [`BCS_ADDR_W-1:0] awaddr_q;
    logic                   w_held_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [1:0]             rresp_q;
    logic [31:0]            rdata_q;
    logic                   do_write;
    logic                   wr_hit;
    logic                   rd_hit;
    logic [31:0]            rd_mux;
    logic [31:0]            status_word;

    // write decode
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign wr_hit        = (awaddr_q == `BCS_REG_CTRL) || (awaddr_q == `BCS_REG_STATUS) ||
                           (awaddr_q == `BCS_REG_SETPOINT) || (awaddr_q == `BCS_REG_TARGET);

    // write channels, response after both halves held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
            w_held_q  <= 1'b0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `BCS_RESP_OKAY;
            ctrl_en_q <= `BCS_CTRL_RST;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr[`BCS_ADDR_W-1:2], 2'h0};
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? `BCS_RESP_OKAY : `BCS_RESP_SLVERR;
                if (awaddr_q == `BCS_REG_CTRL && wstrb_q[0]) ctrl_en_q <= wdata_q[0];
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // status word fields
    assign status_word[`BCS_ST_STATE] = state_q;
    assign status_word[`BCS_ST_LOCK]  = lockout_q;
    assign status_word[`BCS_ST_THERM] = thermal_q;
    assign status_word[`BCS_ST_OC]    = oc_s;
    assign status_word[`BCS_ST_EXT]   = ext_mode_q;
    assign status_word[`BCS_ST_ATTGT] = at_target;
    assign status_word[`BCS_ST_HICNT] = hic_events_q;
    assign status_word[`BCS_ST_ZERO]  = 16'h0000;

    // read decode
    assign rd_hit = (s_axi_araddr[`BCS_ADDR_W-1:2] <= `BCS_REG_TARGET >> 2);
    assign rd_mux = (s_axi_araddr[`BCS_ADDR_W-1:2] == `BCS_REG_CTRL >> 2)     ? {31'h0, ctrl_en_q} :
                    (s_axi_araddr[`BCS_ADDR_W-1:2] == `BCS_REG_STATUS >> 2)   ? status_word :
                    (s_axi_araddr[`BCS_ADDR_W-1:2] == `BCS_REG_SETPOINT >> 2) ? {20'h0, ref_q} :
                    (s_axi_araddr[`BCS_ADDR_W-1:2] == `BCS_REG_TARGET >> 2)   ? {20'h0, target_q} :
                    32'h0000_0000;
    assign s_axi_arready = !rvalid_q;

    // read channel, data registered one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= `BCS_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? `BCS_RESP_OKAY : `BCS_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ---- checks ----
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    soft_start_zero_a: assert property (
        (state_q == bcs_pkg::BCS_OFF && state_d == bcs_pkg::BCS_RAMP)
            |=> (ref_q == 12'h000) && switch_en)
        else $error("soft start does not begin from zero");

    preset_slew_a: assert property (
        (active_q && !ext_mode_q && $changed(ref_q) && $past(active_q))
            |=> (!active_q || $stable(ref_q))[*6])
        else $error("preset ramp steps too fast");

    ext_ramp_time_a: assert property (
        (active_q && ext_mode_q && $changed(ref_q) && $past(active_q))
            |=> (!active_q || $stable(ref_q))[*8])
        else $error("divider ramp steps too fast");

    oc_force_low_a: assert property (
        (oc_s && active_q && run_req) |=> hs_off_ls_on && !switch_en)
        else $error("overcurrent did not force output low");

    hiccup_restart_a: assert property (
        (state_q == bcs_pkg::BCS_HICCUP && hic_done && run_req)
            |=> state_q == bcs_pkg::BCS_RAMP && ref_q == 12'h000)
        else $error("hiccup did not restart with soft start");

    lockout_gate_a: assert property (
        lockout_q |=> !switch_en)
        else $error("switching while locked out");

    lockout_hyst_a: assert property (
        (lockout_q && !sup_rise_s) |=> lockout_q)
        else $error("lockout released below rising threshold");

    enable_low_off_a: assert property (
        !en_s |=> !switch_en && ref_code == 12'h000)
        else $error("enable low did not shut down");

    thermal_off_a: assert property (
        thermal_q |=> !switch_en ##1 !switch_en)
        else $error("output on during thermal shutdown");

    thermal_restart_a: assert property (
        (state_q == bcs_pkg::BCS_THERMAL && !thermal_q) |=> state_q == bcs_pkg::BCS_OFF)
        else $error("no restart after cooling");

    decode_1v2_a: assert property (
        (state_q == bcs_pkg::BCS_OFF && sel_s == 3'h3) |=> target_q == `BCS_MV_1V2)
        else $error("select 011 not decoded");

    ext_select_a: assert property (
        (state_q == bcs_pkg::BCS_OFF && sel_ext)
            |=> use_divider_feedback_pin && target_q == `BCS_MV_EXT)
        else $error("divider mode not selected");

    level_step_a: assert property (
        (state_q == bcs_pkg::BCS_REG && state_d == bcs_pkg::BCS_REG && step_tick
         && ref_q < target_q) |=> ref_q == $past(ref_q) + 12'h001)
        else $error("level change not a single step");

    hiccup_seen_c: cover property ($rose(hs_off_ls_on));
    thermal_seen_c: cover property (state_q == bcs_pkg::BCS_THERMAL ##1 !thermal_q);
    ext_regulate_c: cover property (ext_mode_q && state_q == bcs_pkg::BCS_REG);
    level_move_c: cover property (state_q == bcs_pkg::BCS_REG && $changed(target_q));
endmodule // bcs_sequencer

`default_nettype wire

// ==== tb/bcs_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// host side driving the enable and select pins from bench requests
module bcs_host_model (
    input  wire logic       aclk,
    input  wire logic       run_req,
    input  wire logic [2:0] sel_req,
    input  wire logic       supply_ok,
    output logic            enable_pin = 1'b0,
    output logic [2:0]      sel_pins = 3'h0
);
    // pins move just after the clock edge
    always_ff @(posedge aclk) begin
        enable_pin <= run_req & (supply_ok | enable_pin);
        if (!enable_pin || ((sel_req == 3'h7) == (sel_pins == 3'h7))) begin
            sel_pins <= sel_req;
        end
    end
endmodule // bcs_host_model

`default_nettype wire

// ==== tb/buck_converter_sequencer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "bcs_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
`define WAITC(c, m) for (cyc = 0; cyc < (m) && !(c); cyc++) @(negedge aclk);

module buck_converter_sequencer_tb;
    localparam int HIC = 50;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        run_req = 1'b0, supply_above_rise = 1'b0, supply_above_fall = 1'b0;
    logic        hs_overcurrent = 1'b0, temp_above_trip = 1'b0, temp_above_cool = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [2:0]  sel_req = 3'h0, sel_pins;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        enable_pin, switch_en, hs_off_ls_on, use_divider_feedback_pin;
    logic [11:0] ref_code, mv_tab [0:6];
    int          err_total = 0, samples_checked = 0, cyc, n;

    assign mv_tab = '{`BCS_MV_3V3, `BCS_MV_2V5, `BCS_MV_2V8, `BCS_MV_1V2, `BCS_MV_3V0,
                      `BCS_MV_1V8, `BCS_MV_2V7};

    // clock generation
    always #25 aclk = ~aclk;

    bcs_host_model u_bcs_host_model (.aclk, .run_req, .sel_req,
        .supply_ok(supply_above_fall), .enable_pin, .sel_pins);

    bcs_sequencer #(.HICCUP_CYCLES(HIC)) u_bcs_sequencer (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enable_pin,
        .volt_sel_bit0(sel_pins[0]), .volt_sel_bit1(sel_pins[1]),
        .volt_sel_bit2(sel_pins[2]), .supply_above_rise, .supply_above_fall,
        .hs_overcurrent, .temp_above_trip, .temp_above_cool, .switch_en, .hs_off_ls_on,
        .ref_code, .use_divider_feedback_pin);

    // one register access; each channel released at its own handshake
    task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                q = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        `CHK(k < 50, 1'b1)
    endtask

    // follow the setpoint up to a target, rising at most one code per cycle
    task ramp(input logic [11:0] tgt, input int lim);
        logic [11:0] prev;
        prev = ref_code;
        for (n = 0; n < lim && ref_code !== tgt; n++) begin
            @(negedge aclk);
            `CHK(12'(ref_code - prev) <= 12'h001, 1'b1)
            prev = ref_code;
        end
        `CHK(ref_code, tgt)
    endtask

    task t_bus_decode;
        axi(1'b0, `BCS_REG_CTRL, 32'h0);
        `CHK(q[0], `BCS_CTRL_RST)
        axi(1'b0, 8'h10, 32'h0);
        `CHK({r, q}, {`BCS_RESP_SLVERR, 32'h0})
        for (int i = 0; i < 7; i++) begin
            sel_req <= 3'(i);
            repeat (8) @(posedge aclk);
            axi(1'b0, `BCS_REG_TARGET, 32'h0);
            `CHK(q[11:0], mv_tab[i])
        end
    endtask

    task t_start;
        sel_req <= 3'h3;
        supply_above_fall <= 1'b1;
        run_req <= 1'b1;
        repeat (20) @(negedge aclk);
        `CHK(switch_en, 1'b0)
        supply_above_rise <= 1'b1;
        `WAITC(switch_en, 10)
        `CHK({switch_en, use_divider_feedback_pin}, 2'b10)
        ramp(`BCS_MV_1V2, 10000);
        `CHK((n + 8) / 1200, 7)
        sel_req <= 3'h5;
        ramp(`BCS_MV_1V8, 6000);
        `CHK(switch_en, 1'b1)
    endtask

    task t_hiccup;
        hs_overcurrent <= 1'b1;
        `WAITC(hs_off_ls_on, 10)
        `CHK({hs_off_ls_on, ref_code}, {1'b1, 12'h000})
        for (n = 0; n < 200 && hs_off_ls_on; n++) @(negedge aclk);
        `CHK(n, HIC)
        `WAITC(hs_off_ls_on, 20)
        `CHK(hs_off_ls_on, 1'b1)
        hs_overcurrent <= 1'b0;
        `WAITC(!hs_off_ls_on, 100)
        axi(1'b0, `BCS_REG_STATUS, 32'h0);
        `CHK({q[15:8], q[2:0]}, {8'h02, 3'h1})
    endtask

    task t_thermal_supply;
        temp_above_trip <= 1'b1;
        temp_above_cool <= 1'b1;
        `WAITC(!switch_en, 10)
        `CHK(switch_en, 1'b0)
        temp_above_trip <= 1'b0;
        repeat (20) @(negedge aclk);
        `CHK(switch_en, 1'b0)
        temp_above_cool <= 1'b0;
        `WAITC(switch_en, 10)
        `CHK({switch_en, ref_code < 12'h010}, 2'b11)
        supply_above_rise <= 1'b0;
        supply_above_fall <= 1'b0;
        `WAITC(!switch_en, 10)
        `CHK(switch_en, 1'b0)
        supply_above_fall <= 1'b1;
        repeat (20) @(negedge aclk);
        `CHK(switch_en, 1'b0)
        supply_above_rise <= 1'b1;
        `WAITC(switch_en, 10)
        `CHK(switch_en, 1'b1)
    endtask

    task t_enable_divider;
        axi(1'b1, `BCS_REG_CTRL, 32'h0);
        `WAITC(!switch_en, 5)
        `CHK({r, switch_en}, {`BCS_RESP_OKAY, 1'b0})
        axi(1'b1, `BCS_REG_CTRL, 32'h1);
        `WAITC(switch_en, 5)
        run_req <= 1'b0;
        `WAITC(!switch_en, 10)
        `CHK(switch_en, 1'b0)
        sel_req <= 3'h7;
        repeat (8) @(posedge aclk);
        run_req <= 1'b1;
        `WAITC(switch_en, 15)
        ramp(`BCS_MV_EXT, 40000);
        `CHK({(n + 8) / 603, use_divider_feedback_pin}, {32'd52, 1'b1})
        axi(1'b0, `BCS_REG_STATUS, 32'h0);
        `CHK({q[7:6], q[2:0]}, {2'b11, 3'h2})
    endtask

    task conclude;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // main sequence after a six cycle reset
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_bus_decode();
        t_start();
        t_hiccup();
        t_thermal_supply();
        t_enable_divider();
        conclude();
    end

    // watchdog sized well above the longest expected run
    initial begin
        repeat (70000) @(posedge aclk);
        err_total++;
        conclude();
    end
endmodule // buck_converter_sequencer_tb

`default_nettype wire
